// ==== core/pad_ctrl_pkg.sv ====
// Shared constants and types for the open-drain bus pad control block
package pad_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] BUS_PAD0_CONTROL_ADDR = 32'h4004_4010;
  localparam logic [31:0] BUS_PAD1_CONTROL_ADDR = 32'h4004_4014;
  localparam logic [31:0] PAD_STATUS_ADDR       = 32'h4004_4018;

  localparam int NUM_PADS     = 2;
  localparam int NUM_DIV_CLKS = 7;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int PIN_FUNCTION_SELECT_LSB   = 0;
  localparam int MODE_LSB   = 8;
  localparam int SCOUNT_LSB = 11;
  localparam int CLKSEL_LSB = 13;

  localparam logic [2:0] PIN_FUNCTION_SELECT_GPIO       = 3'h0;
  localparam logic [2:0] PIN_FUNCTION_SELECT_BUS        = 3'h1;
  localparam logic [2:0] CLKSEL_RESERVED = 3'h7;
  localparam logic [1:0] SCOUNT_BYPASS   = 2'h0;
  localparam logic       FILTER_RESET_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    MODE_STD_FAST  = 2'b00,
    MODE_PLAIN_IO  = 2'b01,
    MODE_FAST_PLUS = 2'b10,
    MODE_RESERVED  = 2'b11
  } bus_pad_mode_t;

  typedef struct packed {
    logic [2:0]    filter_clock_select;
    logic [1:0]    sample_count;
    bus_pad_mode_t bus_pad_mode;
    logic [2:0]    pin_function_select;
  } pad_cfg_t;

  localparam pad_cfg_t PAD_CFG_RESET = '0;

  typedef struct packed {
    logic pad_o;
    logic pad_oe_n;
    logic fast_plus;
    logic bus_spike_filter_en;
    logic plain_io;
  } pad_drive_t;

  localparam pad_drive_t PAD_DRIVE_RESET = '{pad_o: 1'b0, pad_oe_n: 1'b1, fast_plus: 1'b0,
                                             bus_spike_filter_en: 1'b1, plain_io: 1'b0};

  // ----------------------------------------------------------------
  // APB carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    pad_cfg_t [NUM_PADS-1:0]   cfg;
    logic [31:0]               rdata;
    logic [NUM_PADS-1:0]       sync1;
    logic [NUM_PADS-1:0]       sync2;
    pad_drive_t [NUM_PADS-1:0] drive;
  } top_state_t;

  typedef struct packed {
    logic       level;
    logic [1:0] run;
  } filt_state_t;

  // ----------------------------------------------------------------
  // Word packing
  // ----------------------------------------------------------------
  function automatic logic [31:0] cfg_to_word(input pad_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PIN_FUNCTION_SELECT_LSB +: 3]   = c.pin_function_select;
    w[MODE_LSB +: 2]   = c.bus_pad_mode;
    w[SCOUNT_LSB +: 2] = c.sample_count;
    w[CLKSEL_LSB +: 3] = c.filter_clock_select;
    return w;
  endfunction : cfg_to_word

  function automatic pad_cfg_t word_to_cfg(input logic [31:0] w);
    pad_cfg_t c;
    c.pin_function_select = w[PIN_FUNCTION_SELECT_LSB +: 3];
    c.bus_pad_mode        = bus_pad_mode_t'(w[MODE_LSB +: 2]);
    c.sample_count        = w[SCOUNT_LSB +: 2];
    c.filter_clock_select = w[CLKSEL_LSB +: 3];
    return c;
  endfunction : word_to_cfg

endpackage : pad_ctrl_pkg

// ==== core/pad_input_filter.sv ====
// Digital glitch filter for one pad input, sampled on a shared divider tick
`timescale 1ns/10ps
`default_nettype none

module pad_input_filter
  import pad_ctrl_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  input  wire logic                    raw_in,
  input  wire logic [1:0]              sample_count,
  input  wire logic [2:0]              filter_clock_select,
  input  wire logic [NUM_DIV_CLKS-1:0] div_tick,
  output logic                         filt_out
);

  filt_state_t state_reg;
  filt_state_t state_next;
  logic        tick;
  logic [2:0]  run_inc;

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  // Reserved select has no tick, so outside bypass the filter holds its level
  always_comb begin
    if (filter_clock_select == CLKSEL_RESERVED) begin
      tick = 1'b0;
    end else begin
      tick = div_tick[filter_clock_select];
    end
  end

  // ----------------------------------------------------------------
  // Filter state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    run_inc    = {1'b0, state_reg.run} + 3'h1;
    if (sample_count == SCOUNT_BYPASS) begin
      state_next.level = raw_in;
      state_next.run   = 2'h0;
    end else if (raw_in == state_reg.level) begin
      state_next.run = 2'h0;
    end else if (tick) begin
      // New level must survive sample_count ticks in a row
      if (run_inc >= {1'b0, sample_count}) begin
        state_next.level = raw_in;
        state_next.run   = 2'h0;
      end else begin
        state_next.run = run_inc[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{level: FILTER_RESET_LEVEL, run: 2'h0};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign filt_out = state_reg.level;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_bypass_follow: assert property (
    clk_en && sample_count == SCOUNT_BYPASS |=> filt_out == $past(raw_in))
    else $error("bypassed filter did not follow input");

  chk_pulse_reject: assert property (
    $changed(filt_out) && $past(sample_count) != SCOUNT_BYPASS
      |-> $past(tick) && ({1'b0, $past(state_reg.run)} + 3'h1 >= {1'b0, $past(sample_count)}))
    else $error("filter output changed before enough ticks");

  chk_hold_no_tick: assert property (
    sample_count != SCOUNT_BYPASS && !tick |=> $stable(filt_out))
    else $error("filter output moved without a tick");

  chk_reserved_sel: assert property (
    filter_clock_select == CLKSEL_RESERVED |-> !tick)
    else $error("reserved filter clock produced a tick");

  cov_filter_change: cover property (
    sample_count == 2'h3 ##1 $changed(filt_out));

endmodule : pad_input_filter

`default_nettype wire

// ==== core/open_drain_bus_pad_control.sv ====
// Control registers and pad logic for the two open-drain bus pads
`timescale 1ns/10ps
`default_nettype none

module open_drain_bus_pad_control
  import pad_ctrl_pkg::*;
(
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               clk_en,
  input  wire pad_ctrl_pkg::apb_req_t             apb_req,
  output pad_ctrl_pkg::apb_rsp_t                  apb_rsp,
  input  wire logic [pad_ctrl_pkg::NUM_DIV_CLKS-1:0] pin_filter_divider_clock,
  input  wire logic [pad_ctrl_pkg::NUM_PADS-1:0]  gpio_out_value,
  input  wire logic [pad_ctrl_pkg::NUM_PADS-1:0]  gpio_out_enable,
  input  wire logic [pad_ctrl_pkg::NUM_PADS-1:0]  bus_drive_low,
  input  wire logic [pad_ctrl_pkg::NUM_PADS-1:0]  pad_i,
  output pad_ctrl_pkg::pad_drive_t [pad_ctrl_pkg::NUM_PADS-1:0] pad_drive,
  output pad_ctrl_pkg::pad_cfg_t [pad_ctrl_pkg::NUM_PADS-1:0]   pad_config,
  output logic [pad_ctrl_pkg::NUM_PADS-1:0]       pad_in_value
);

  import pad_ctrl_pkg::*;

  top_state_t          state_reg;
  top_state_t          state_next;
  logic                setup_phase;
  logic                access_phase;
  logic [1:0]          hit_pad;
  logic                hit_status;
  logic                unmapped;
  logic [NUM_PADS-1:0] filtered;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Full-address compare; the block sits at a fixed system address
  always_comb begin
    hit_pad[0] = (apb_req.paddr == BUS_PAD0_CONTROL_ADDR);
    hit_pad[1] = (apb_req.paddr == BUS_PAD1_CONTROL_ADDR);
    hit_status = (apb_req.paddr == PAD_STATUS_ADDR);
    unmapped   = !(hit_pad[0] || hit_pad[1] || hit_status);
  end

  assign setup_phase  = apb_req.psel && !apb_req.penable;
  assign access_phase = apb_req.psel && apb_req.penable;

  // Stall the bus while frozen so no write is taken and then lost
  assign apb_rsp.pready  = access_phase && clk_en;
  assign apb_rsp.pslverr = access_phase && clk_en && unmapped;
  assign apb_rsp.prdata  = state_reg.rdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Pad input synchronisers
    state_next.sync1 = pad_i;
    state_next.sync2 = state_reg.sync1;

    // Read data is captured in the setup cycle, ahead of any write
    if (setup_phase && !apb_req.pwrite) begin
      if (hit_pad[0]) begin
        state_next.rdata = cfg_to_word(state_reg.cfg[0]);
      end else if (hit_pad[1]) begin
        state_next.rdata = cfg_to_word(state_reg.cfg[1]);
      end else if (hit_status) begin
        state_next.rdata = {{(32-NUM_PADS){1'b0}}, filtered};
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end

    // Writes only keep the defined fields
    if (access_phase && apb_req.pwrite) begin
      for (int p = 0; p < NUM_PADS; p++) begin
        if (hit_pad[p]) begin
          state_next.cfg[p] = word_to_cfg(apb_req.pwdata);
        end
      end
    end

    // Pad drivers: the pad can only pull low
    for (int p = 0; p < NUM_PADS; p++) begin
      state_next.drive[p].pad_o = 1'b0;
      case (state_reg.cfg[p].pin_function_select)
        PIN_FUNCTION_SELECT_GPIO: begin
          state_next.drive[p].pad_oe_n = !(gpio_out_enable[p] && !gpio_out_value[p]);
        end
        PIN_FUNCTION_SELECT_BUS: begin
          state_next.drive[p].pad_oe_n = !bus_drive_low[p];
        end
        default: begin
          state_next.drive[p].pad_oe_n = 1'b1;
        end
      endcase
      case (state_reg.cfg[p].bus_pad_mode)
        MODE_STD_FAST: begin
          state_next.drive[p].fast_plus           = 1'b0;
          state_next.drive[p].bus_spike_filter_en = 1'b1;
          state_next.drive[p].plain_io            = 1'b0;
        end
        MODE_PLAIN_IO: begin
          state_next.drive[p].fast_plus           = 1'b0;
          state_next.drive[p].bus_spike_filter_en = 1'b0;
          state_next.drive[p].plain_io            = 1'b1;
        end
        MODE_FAST_PLUS: begin
          state_next.drive[p].fast_plus           = 1'b1;
          state_next.drive[p].bus_spike_filter_en = 1'b1;
          state_next.drive[p].plain_io            = 1'b0;
        end
        default: begin
          // Reserved code behaves as the reset bus mode
          state_next.drive[p].fast_plus           = 1'b0;
          state_next.drive[p].bus_spike_filter_en = 1'b1;
          state_next.drive[p].plain_io            = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.cfg   <= {NUM_PADS{PAD_CFG_RESET}};
      state_reg.rdata <= 32'h0000_0000;
      // Idle high, as the filter, so no false edge follows reset
      state_reg.sync1 <= {NUM_PADS{FILTER_RESET_LEVEL}};
      state_reg.sync2 <= {NUM_PADS{FILTER_RESET_LEVEL}};
      state_reg.drive <= {NUM_PADS{PAD_DRIVE_RESET}};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Input filters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_PADS; g++) begin : gen_filter
    pad_input_filter u_filter (
      .pclk                (pclk),
      .presetn             (presetn),
      .clk_en              (clk_en),
      .raw_in              (state_reg.sync2[g]),
      .sample_count        (state_reg.cfg[g].sample_count),
      .filter_clock_select (state_reg.cfg[g].filter_clock_select),
      .div_tick            (pin_filter_divider_clock),
      .filt_out            (filtered[g])
    );
  end

  assign pad_drive    = state_reg.drive;
  assign pad_config   = state_reg.cfg;
  assign pad_in_value = filtered;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pin_function_select_write: assert property (
    apb_rsp.pready && apb_req.pwrite && hit_pad[0]
      |=> pad_config[0].pin_function_select == $past(apb_req.pwdata[2:0]))
    else $error("function select did not take written value");

  chk_mode_write: assert property (
    apb_rsp.pready && apb_req.pwrite && hit_pad[1]
      |=> pad_config[1].bus_pad_mode == $past(apb_req.pwdata[9:8]))
    else $error("pad mode did not take written value");

  chk_gpio_pull_low: assert property (
    clk_en && pad_config[0].pin_function_select == PIN_FUNCTION_SELECT_GPIO
      && gpio_out_enable[0] && !gpio_out_value[0]
      |=> !pad_drive[0].pad_oe_n && !pad_drive[0].pad_o)
    else $error("plain output low did not pull the pad low");

  chk_never_high: assert property (
    !pad_drive[0].pad_oe_n || !pad_drive[1].pad_oe_n |-> !pad_drive[0].pad_o && !pad_drive[1].pad_o)
    else $error("pad driven high");

  chk_pad_isolate: assert property (
    apb_rsp.pready && apb_req.pwrite && hit_pad[1] |=> $stable(pad_config[0]))
    else $error("pad1 write disturbed pad0");

  chk_reserved_read: assert property (
    clk_en && setup_phase && !apb_req.pwrite && (hit_pad[0] || hit_pad[1])
      |=> apb_rsp.prdata[7:3] == 5'h00 && !apb_rsp.prdata[10]
          && apb_rsp.prdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");

  chk_sample_write: assert property (
    apb_rsp.pready && apb_req.pwrite && hit_pad[0]
      |=> pad_config[0].sample_count == $past(apb_req.pwdata[12:11])
          && pad_config[0].filter_clock_select == $past(apb_req.pwdata[15:13]))
    else $error("filter fields did not take written value");

  chk_fast_plus: assert property (
    clk_en && pad_config[1].bus_pad_mode == MODE_FAST_PLUS |=> pad_drive[1].fast_plus)
    else $error("fast-plus mode not reflected on pad");

  chk_unmapped_err: assert property (
    apb_rsp.pready && unmapped |-> apb_rsp.pslverr)
    else $error("unmapped access without error");

  cov_pad0_write: cover property (apb_rsp.pready && apb_req.pwrite && hit_pad[0]);
  cov_pad1_read:  cover property (apb_rsp.pready && !apb_req.pwrite && hit_pad[1]);
  cov_plain_io:   cover property (pad_drive[0].plain_io && !pad_drive[0].pad_oe_n);

endmodule : open_drain_bus_pad_control

`default_nettype wire

// ==== verif/test_open_drain_bus_pad_control.sv ====
// Self-checking bench for the open-drain bus pad control block
`timescale 1ns/10ps
`default_nettype none

module test_open_drain_bus_pad_control;
  import pad_ctrl_pkg::*;

  logic                      pclk;
  logic                      presetn;
  logic                      clk_en;
  apb_req_t                  req;
  apb_rsp_t                  rsp;
  logic [NUM_DIV_CLKS-1:0]   tick;
  logic [NUM_PADS-1:0]       gv;
  logic [NUM_PADS-1:0]       ge;
  logic [NUM_PADS-1:0]       bl;
  logic [NUM_PADS-1:0]       pin;
  pad_drive_t [NUM_PADS-1:0] drv;
  pad_cfg_t [NUM_PADS-1:0]   cfg;
  logic [NUM_PADS-1:0]       fin;
  int                        mismatches;
  int                        check_count;
  int                        seed;
  int                        sel;
  int                        p;
  logic [31:0]               rd;
  logic                      err;
  logic [31:0]               v;
  logic [31:0]               w [NUM_PADS];

  open_drain_bus_pad_control dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .clk_en                   (clk_en),
    .apb_req                  (req),
    .apb_rsp                  (rsp),
    .pin_filter_divider_clock (tick),
    .gpio_out_value           (gv),
    .gpio_out_enable          (ge),
    .bus_drive_low            (bl),
    .pad_i                    (pin),
    .pad_drive                (drv),
    .pad_config               (cfg),
    .pad_in_value             (fin)
  );

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Stall > 0 drops clk_en in the access phase to force wait states
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     input int stall);
    int n;
    @(posedge pclk);
    req.psel    <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite  <= wr;
    req.paddr   <= addr;
    req.pwdata  <= wd;
    @(posedge pclk);
    req.penable <= 1'h1;
    if (stall > 0) clk_en <= 1'h0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n == stall) begin
        check("stalled pready", 32'h0, {31'h0, rsp.pready});
        clk_en <= 1'h1;
      end
    end while (rsp.pready !== 1'h1 && n < 50);
    if (n >= 50) check("apb answer", 32'h1, 32'h0);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp, input logic exp_err);
    apb(1'h0, addr, 32'h0, 0);
    check("read data", exp, rd);
    check("read error", {31'h0, exp_err}, {31'h0, err});
  endtask : rdchk

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  // Non-selected ticks fire on the miss cycles so a wrong select is caught
  task automatic pulse(input int s, input int hits, input int misses);
    for (int i = 0; i < hits + misses; i++) begin
      @(posedge pclk);
      tick <= (i < hits) ? (7'h01 << s) : ~(7'h01 << s);
      @(posedge pclk);
      tick <= 7'h00;
    end
  endtask : pulse

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_addr(input int pad);
    return BUS_PAD0_CONTROL_ADDR + 32'(4 * pad);
  endfunction : reg_addr

  function automatic logic [9:0] cfg_bits(input logic [31:0] x);
    return {x[15:13], x[12:11], x[9:8], x[2:0]};
  endfunction : cfg_bits

  function automatic logic [4:0] drive_exp(input logic [31:0] x, input logic g_v,
                                           input logic g_e, input logic b_l);
    logic oe_n;
    case (x[2:0])
      3'h0:    oe_n = ~(g_e & ~g_v);
      3'h1:    oe_n = ~b_l;
      default: oe_n = 1'h1;
    endcase
    return {1'h0, oe_n, x[9:8] == 2'h2, x[9:8] != 2'h1, x[9:8] == 2'h1};
  endfunction : drive_exp

  task automatic check_pads();
    for (int q = 0; q < NUM_PADS; q++) begin
      check("pad drive", {27'h0, drive_exp(w[q], gv[q], ge[q], bl[q])}, {27'h0, drv[q]});
      check("pad config", {22'h0, cfg_bits(w[q])}, {22'h0, cfg[q]});
    end
  endtask : check_pads

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 4;
    mismatches = 0;
    check_count = 0;
    presetn = 1'h0;
    clk_en = 1'h1;
    req = '0;
    tick = '0;
    gv = '0;
    ge = '0;
    bl = '0;
    pin = '1;
    w[0] = 32'h0;
    w[1] = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    settle(1);
    check("idle filtered level", 32'h3, {30'h0, fin});
    check_pads();
    for (int q = 0; q < NUM_PADS; q++) rdchk(reg_addr(q), 32'h0, 1'h0);
    rdchk(32'h4004_4020, 32'h0, 1'h1);
    // Every mode and function code, random fields and drive inputs
    for (int i = 0; i < 64; i++) begin
      p = i % 2;
      v = $random(seed);
      v[9:8] = 2'((i >> 1) & 3);
      v[2:0] = 3'((i >> 3) & 7);
      if (v[15:13] == CLKSEL_RESERVED) v[15:13] = 3'h6;
      apb(1'h1, reg_addr(p), v, (i == 5) ? 3 : 0);
      w[p] = v & 32'h0000_FB07;
      gv <= 2'($random(seed));
      ge <= 2'($random(seed));
      bl <= 2'($random(seed));
      settle(2);
      check_pads();
      rdchk(reg_addr(p), w[p], 1'h0);
    end
    apb(1'h1, 32'h4004_401C, 32'hFFFF_FFFF, 0);
    check("unmapped write error", 32'h1, {31'h0, err});
    for (int q = 0; q < NUM_PADS; q++) rdchk(reg_addr(q), w[q], 1'h0);
    // Bypass: three edges from pad to filtered level
    for (int q = 0; q < NUM_PADS; q++) begin
      w[q] = 32'h0000_C000;
      apb(1'h1, reg_addr(q), w[q], 0);
      pin[q] <= 1'h0;
      settle(2);
      check("bypass early", 32'h1, {31'h0, fin[q]});
      settle(1);
      check("bypass level", 32'h0, {31'h0, fin[q]});
      pin[q] <= 1'h1;
      settle(3);
    end
    // Glitch filter: N-1 selected ticks rejected, N accepted
    for (int n = 1; n < 4; n++) begin
      for (int q = 0; q < NUM_PADS; q++) begin
        sel = {$random(seed)} % 7;
        w[q] = {16'h0, 3'(sel), 2'(n), 11'h0};
        apb(1'h1, reg_addr(q), w[q], 0);
        pin[q] <= 1'h0;
        settle(3);
        pulse(sel, n - 1, 4);
        pin[q] <= 1'h1;
        settle(3);
        pulse(sel, 3, 0);
        settle(3);
        check("short pulse", 32'h1, {31'h0, fin[q]});
        pin[q] <= 1'h0;
        settle(3);
        pulse(sel, n, 0);
        settle(3);
        check("long pulse", 32'h0, {31'h0, fin[q]});
        rdchk(PAD_STATUS_ADDR, {30'h0, 2'h3 ^ (2'h1 << q)}, 1'h0);
        pin[q] <= 1'h1;
        settle(3);
        pulse(sel, n, 0);
        settle(3);
        check("filter release", 32'h1, {31'h0, fin[q]});
      end
    end
    // Second reset in mid-run clears the registers again
    presetn <= 1'h0;
    settle(2);
    presetn <= 1'h1;
    settle(1);
    for (int q = 0; q < NUM_PADS; q++) rdchk(reg_addr(q), 32'h0, 1'h0);
    give_verdict();
  end

  // Whole run is under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

endmodule : test_open_drain_bus_pad_control

`default_nettype wire
